/* rtl/dpa_top.sv */
// Dual pointer and coefficient address generator with APB register file
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module dpa_top
    import dpa_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DPA_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Dual operand request from the CPU pipeline
    input wire logic dual_valid,
    input wire logic dual_instr,
    input wire logic [2:0] x_sel,
    input wire logic [2:0] x_mode,
    input wire logic x_long,
    input wire logic [2:0] y_sel,
    input wire logic [2:0] y_mode,
    input wire logic y_long,
    output logic [22:0] x_addr,
    output logic [22:0] y_addr,
    output logic x_long_out,
    output logic y_long_out,
    output logic dual_addr_valid,
    // Coefficient access request
    input wire logic coef_valid,
    input wire logic [1:0] coef_type,
    output logic [22:0] coef_data_addr,
    output logic [5:0] coef_bit_num,
    output logic [15:0] coef_io_addr,
    output logic coef_data_valid,
    output logic coef_bit_valid,
    output logic coef_io_valid
);
    // ============================================================
    // Register state
    logic [22:0] xptr_q [8];
    logic [22:0] xptr_d [8];
    logic [15:0] tmp0_q, tmp0_d, tmp1_q, tmp1_d;
    logic [15:0] bsa_q [4];
    logic [15:0] bsa_d [4];
    logic [8:0] st2_q, st2_d;
    logic compat_q, compat_d, amsel_q, amsel_d;
    logic [22:0] xcoef_q, xcoef_d;
    logic [15:0] bsac_q, bsac_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;

    // Address outputs
    logic [22:0] x_addr_q, x_addr_d, y_addr_q, y_addr_d;
    logic x_long_q, x_long_d, y_long_q, y_long_d;
    logic dav_q, dav_d;
    logic [22:0] cda_q, cda_d;
    logic [5:0] cbit_q, cbit_d;
    logic [15:0] cio_q, cio_d;
    logic cdv_q, cdv_d, cbv_q, cbv_d, civ_q, civ_d;

    // ============================================================
    // Bus decode
    logic [31:0] wmask;
    logic setup, wr_acc;
    logic [5:0] widx;
    logic map_hit;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && ce;
    assign widx = paddr[7:2];
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign map_hit = (paddr[1:0] == 2'b00) && (paddr <= DPA_OFS_LASTY);

    // Merge byte lanes into an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                          input logic [31:0] nw);
        merge = (old & ~m) | (nw & m);
    endfunction

    // ============================================================
    // Address lanes
    logic x_long_eff, y_long_eff;
    logic [22:0] x_ptr_ext, y_ptr_ext, x_a, y_a;
    logic [15:0] x_new, y_new;
    logic x_upd, y_upd;

    // A dual-read instruction is always two single words; a parallel pair may use long words
    assign x_long_eff = x_long && !dual_instr;
    assign y_long_eff = y_long && !dual_instr;
    assign x_ptr_ext = xptr_q[x_sel];
    assign y_ptr_ext = xptr_q[y_sel];

    // First operand lane; the mode select bit deliberately plays no part here
    dpa_agu_lane u_lane_x (
        .ptr_ext(x_ptr_ext),
        .mode(x_mode),
        .long_acc(x_long_eff),
        .circ(st2_q[x_sel]),
        .bsa(bsa_q[x_sel[2:1]]),
        .compat(compat_q),
        .tmp0(tmp0_q),
        .aux0(xptr_q[0][15:0]),
        .tmp1(tmp1_q),
        .addr(x_a),
        .ptr_new(x_new),
        .upd(x_upd)
    );

    // Second operand lane
    dpa_agu_lane u_lane_y (
        .ptr_ext(y_ptr_ext),
        .mode(y_mode),
        .long_acc(y_long_eff),
        .circ(st2_q[y_sel]),
        .bsa(bsa_q[y_sel[2:1]]),
        .compat(compat_q),
        .tmp0(tmp0_q),
        .aux0(xptr_q[0][15:0]),
        .tmp1(tmp1_q),
        .addr(y_a),
        .ptr_new(y_new),
        .upd(y_upd)
    );

    // ============================================================
    // Coefficient path
    logic [22:0] c_da;
    logic [5:0] c_bn;
    logic [15:0] c_io;
    logic c_isd, c_isb, c_isi;

    dpa_coef_addr u_coef (
        .xcoef(xcoef_q),
        .acc_type(coef_type),
        .circ(st2_q[DPA_ST2_COEF_BIT]),
        .bsac(bsac_q),
        .data_addr(c_da),
        .bit_num(c_bn),
        .io_addr(c_io),
        .is_data(c_isd),
        .is_bit(c_isb),
        .is_io(c_isi)
    );

    // ============================================================
    // Pointer and register next state
    // Order: second lane, then first lane, then a software write. Software writes win
    // because a pointer write that enables byte lane 2 is the only way the page changes.
    always_comb begin
        xptr_d = xptr_q;
        tmp0_d = tmp0_q;
        tmp1_d = tmp1_q;
        bsa_d = bsa_q;
        st2_d = st2_q;
        compat_d = compat_q;
        amsel_d = amsel_q;
        xcoef_d = xcoef_q;
        bsac_d = bsac_q;
        // A pointer named by both lanes ends with the first lane's update
        if (dual_valid) begin
            if (y_upd) begin
                xptr_d[y_sel] = {xptr_q[y_sel][22:16], y_new};
            end
            if (x_upd) begin
                xptr_d[x_sel] = {xptr_q[x_sel][22:16], x_new};
            end
        end
        // Size casts keep only the register's own bits of the merged bus word;
        // the upper bus bits of a narrow register are simply dropped, never stored
        if (wr_acc) begin
            if (widx < 6'd8) begin
                xptr_d[widx[2:0]] = 23'(merge({9'h000, xptr_q[widx[2:0]]}, wmask,
                    pwdata));
            end else if ({widx, 2'b00} == DPA_OFS_TMP0) begin
                tmp0_d = 16'(merge({16'h0000, tmp0_q}, wmask, pwdata));
            end else if ({widx, 2'b00} == DPA_OFS_TMP1) begin
                tmp1_d = 16'(merge({16'h0000, tmp1_q}, wmask, pwdata));
            end else if (({widx, 2'b00} >= DPA_OFS_BUFFER_START_PAIR01) && ({widx, 2'b00} < DPA_OFS_ST2))
            begin
                bsa_d[widx[1:0] - 2'd2] = 16'(merge({16'h0000, bsa_q[widx[1:0] - 2'd2]},
                    wmask, pwdata));
            end else if ({widx, 2'b00} == DPA_OFS_ST2) begin
                st2_d = 9'(merge({23'h000000, st2_q}, wmask, pwdata));
            end else if ({widx, 2'b00} == DPA_OFS_CTRL) begin
                if (pstrb[0]) begin
                    compat_d = pwdata[DPA_CTRL_COMPAT_BIT];
                    amsel_d = pwdata[DPA_CTRL_AMSEL_BIT];
                end
            end else if ({widx, 2'b00} == DPA_OFS_XCOEF) begin
                xcoef_d = 23'(merge({9'h000, xcoef_q}, wmask, pwdata));
            end else if ({widx, 2'b00} == DPA_OFS_BSAC) begin
                bsac_d = 16'(merge({16'h0000, bsac_q}, wmask, pwdata));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                xptr_q[i] <= DPA_RST_XPTR;
            end
            for (int i = 0; i < 4; i++) begin
                bsa_q[i] <= DPA_RST_REG16;
            end
            tmp0_q <= DPA_RST_REG16;
            tmp1_q <= DPA_RST_REG16;
            st2_q <= DPA_RST_ST2;
            compat_q <= 1'b0;
            amsel_q <= 1'b0;
            xcoef_q <= DPA_RST_XPTR;
            bsac_q <= DPA_RST_REG16;
        end else if (ce) begin
            xptr_q <= xptr_d;
            bsa_q <= bsa_d;
            tmp0_q <= tmp0_d;
            tmp1_q <= tmp1_d;
            st2_q <= st2_d;
            compat_q <= compat_d;
            amsel_q <= amsel_d;
            xcoef_q <= xcoef_d;
            bsac_q <= bsac_d;
        end
    end

    // ============================================================
    // Read data is captured in the setup cycle so prdata comes from a flop
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            prdata_d = 32'h00000000;
            pslverr_d = !map_hit;
            if (widx < 6'd8) begin
                prdata_d = {9'h000, xptr_q[widx[2:0]]};
            end else begin
                case ({widx, 2'b00})
                    DPA_OFS_TMP0: prdata_d = {16'h0000, tmp0_q};
                    DPA_OFS_TMP1: prdata_d = {16'h0000, tmp1_q};
                    DPA_OFS_ST2: prdata_d = {23'h000000, st2_q};
                    DPA_OFS_CTRL: prdata_d = {30'h00000000, amsel_q, compat_q};
                    DPA_OFS_XCOEF: prdata_d = {9'h000, xcoef_q};
                    DPA_OFS_BSAC: prdata_d = {16'h0000, bsac_q};
                    DPA_OFS_LASTX: prdata_d = {9'h000, x_addr_q};
                    DPA_OFS_LASTY: prdata_d = {9'h000, y_addr_q};
                    default: begin
                        if (({widx, 2'b00} >= DPA_OFS_BUFFER_START_PAIR01) && ({widx, 2'b00} < DPA_OFS_ST2))
                        begin
                            prdata_d = {16'h0000, bsa_q[widx[1:0] - 2'd2]};
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Zero wait states; a frozen block holds the access open
    assign pready = ce;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q && psel && penable;

    // ============================================================
    // Issued addresses, registered at the same edge that commits the pointers
    always_comb begin
        x_addr_d = x_addr_q;
        y_addr_d = y_addr_q;
        x_long_d = x_long_q;
        y_long_d = y_long_q;
        dav_d = dual_valid;
        if (dual_valid) begin
            x_addr_d = x_a;
            y_addr_d = y_a;
            x_long_d = x_long_eff;
            y_long_d = y_long_eff;
        end
        cda_d = cda_q;
        cbit_d = cbit_q;
        cio_d = cio_q;
        cdv_d = coef_valid && c_isd;
        cbv_d = coef_valid && c_isb;
        civ_d = coef_valid && c_isi;
        if (coef_valid) begin
            cda_d = c_da;
            cbit_d = c_bn;
            cio_d = c_io;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_addr_q <= DPA_RST_XPTR;
            y_addr_q <= DPA_RST_XPTR;
            x_long_q <= 1'b0;
            y_long_q <= 1'b0;
            dav_q <= 1'b0;
            cda_q <= DPA_RST_XPTR;
            cbit_q <= 6'h00;
            cio_q <= DPA_RST_REG16;
            cdv_q <= 1'b0;
            cbv_q <= 1'b0;
            civ_q <= 1'b0;
        end else if (ce) begin
            x_addr_q <= x_addr_d;
            y_addr_q <= y_addr_d;
            x_long_q <= x_long_d;
            y_long_q <= y_long_d;
            dav_q <= dav_d;
            cda_q <= cda_d;
            cbit_q <= cbit_d;
            cio_q <= cio_d;
            cdv_q <= cdv_d;
            cbv_q <= cbv_d;
            civ_q <= civ_d;
        end
    end

    assign x_addr = x_addr_q;
    assign y_addr = y_addr_q;
    assign x_long_out = x_long_q;
    assign y_long_out = y_long_q;
    assign dual_addr_valid = dav_q;
    assign coef_data_addr = cda_q;
    assign coef_bit_num = cbit_q;
    assign coef_io_addr = cio_q;
    assign coef_data_valid = cdv_q;
    assign coef_bit_valid = cbv_q;
    assign coef_io_valid = civ_q;
endmodule // dpa_top

/* inc/dpa_pkg.sv */
// Constants, register map and types for the dual pointer and coefficient address generator
package dpa_pkg;
    localparam int unsigned DPA_AW = 8;
    // ============================================================
    // Register byte offsets
    localparam logic [7:0] DPA_OFS_XPTR0 = 8'h00;  // Eight words, one per pointer
    localparam logic [7:0] DPA_OFS_TMP0 = 8'h20;
    localparam logic [7:0] DPA_OFS_TMP1 = 8'h24;
    localparam logic [7:0] DPA_OFS_BUFFER_START_PAIR01 = 8'h28;  // Four words, one per pointer pair
    localparam logic [7:0] DPA_OFS_ST2 = 8'h38;
    localparam logic [7:0] DPA_OFS_CTRL = 8'h3C;
    localparam logic [7:0] DPA_OFS_XCOEF = 8'h40;
    localparam logic [7:0] DPA_OFS_BSAC = 8'h44;
    localparam logic [7:0] DPA_OFS_LASTX = 8'h48;
    localparam logic [7:0] DPA_OFS_LASTY = 8'h4C;
    // ============================================================
    // Field positions
    localparam int unsigned DPA_ST2_COEF_BIT = 8;   // Bits 0..7 circular flag per pointer
    localparam int unsigned DPA_CTRL_COMPAT_BIT = 0;
    localparam int unsigned DPA_CTRL_AMSEL_BIT = 1;
    // ============================================================
    // Reset values
    localparam logic [22:0] DPA_RST_XPTR = 23'h000000;
    localparam logic [15:0] DPA_RST_REG16 = 16'h0000;
    localparam logic [8:0] DPA_RST_ST2 = 9'h000;
    // ============================================================
    // Step sizes
    localparam logic [15:0] DPA_STEP_SHORT = 16'h0001;
    localparam logic [15:0] DPA_STEP_LONG = 16'h0002;
    // ============================================================
    // Types
    typedef enum logic [2:0] {
        DPA_MOD_NONE,
        DPA_MOD_INC,
        DPA_MOD_DEC,
        DPA_MOD_ADD_IDX,
        DPA_MOD_SUB_IDX,
        DPA_MOD_BASE_IDX,
        DPA_MOD_ADD_T1,
        DPA_MOD_SUB_T1
    } dpa_mod_t;
    typedef enum logic [1:0] {
        DPA_CA_DATA,
        DPA_CA_BIT,
        DPA_CA_IO
    } dpa_cacc_t;
endpackage

/* rtl/dpa_agu_lane.sv */
// One dual-operand address lane: address and pointer update for one access
`timescale 1ns/1ps
module dpa_agu_lane
    import dpa_pkg::*;
(
    input wire logic [22:0] ptr_ext,
    input wire logic [2:0] mode,
    input wire logic long_acc,
    input wire logic circ,
    input wire logic [15:0] bsa,
    input wire logic compat,
    input wire logic [15:0] tmp0,
    input wire logic [15:0] aux0,
    input wire logic [15:0] tmp1,
    output logic [22:0] addr,
    output logic [15:0] ptr_new,
    output logic upd
);
    logic [15:0] ptr;
    logic [15:0] step;
    logic [15:0] idx;
    logic [15:0] off;
    logic [15:0] lin;

    assign ptr = ptr_ext[15:0];
    assign step = long_acc ? DPA_STEP_LONG : DPA_STEP_SHORT;
    assign idx = compat ? aux0 : tmp0;

    // Modification forms; 16-bit sums wrap naturally and never touch the page
    always_comb begin
        off = 16'h0000;
        ptr_new = ptr;
        upd = 1'b0;
        case (dpa_mod_t'(mode))
            DPA_MOD_NONE: upd = 1'b0;
            DPA_MOD_INC: begin
                ptr_new = ptr + step;
                upd = 1'b1;
            end
            DPA_MOD_DEC: begin
                ptr_new = ptr - step;
                upd = 1'b1;
            end
            DPA_MOD_ADD_IDX: begin
                ptr_new = ptr + idx;
                upd = 1'b1;
            end
            DPA_MOD_SUB_IDX: begin
                ptr_new = ptr - idx;
                upd = 1'b1;
            end
            DPA_MOD_BASE_IDX: off = idx;
            DPA_MOD_ADD_T1: begin
                ptr_new = ptr + tmp1;
                upd = 1'b1;
            end
            DPA_MOD_SUB_T1: begin
                ptr_new = ptr - tmp1;
                upd = 1'b1;
            end
            default: upd = 1'b0;
        endcase
    end

    // Base is added only in circular mode; a carry out of bit 15 is dropped
    assign lin = ptr + off;
    assign addr = {ptr_ext[22:16], circ ? lin + bsa : lin};
endmodule // dpa_agu_lane

/* rtl/dpa_coef_addr.sv */
// Coefficient pointer interpretation by access type
`timescale 1ns/1ps
module dpa_coef_addr
    import dpa_pkg::*;
(
    input wire logic [22:0] xcoef,
    input wire logic [1:0] acc_type,
    input wire logic circ,
    input wire logic [15:0] bsac,
    output logic [22:0] data_addr,
    output logic [5:0] bit_num,
    output logic [15:0] io_addr,
    output logic is_data,
    output logic is_bit,
    output logic is_io
);
    logic [15:0] low;

    assign low = circ ? xcoef[15:0] + bsac : xcoef[15:0];
    assign data_addr = {xcoef[22:16], low};
    assign bit_num = xcoef[5:0];
    assign io_addr = xcoef[15:0];
    assign is_data = dpa_cacc_t'(acc_type) == DPA_CA_DATA;
    assign is_bit = dpa_cacc_t'(acc_type) == DPA_CA_BIT;
    assign is_io = dpa_cacc_t'(acc_type) == DPA_CA_IO;
endmodule // dpa_coef_addr

/* tb/dpa_top_chk.sv */
// Port checker for the dual pointer and coefficient address generator
`timescale 1ns/1ps
module dpa_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic dual_valid,
    input wire logic dual_instr,
    input wire logic [2:0] x_sel,
    input wire logic [2:0] x_mode,
    input wire logic x_long,
    input wire logic [2:0] y_sel,
    input wire logic [2:0] y_mode,
    input wire logic y_long,
    input wire logic [22:0] x_addr,
    input wire logic [22:0] y_addr,
    input wire logic x_long_out,
    input wire logic y_long_out,
    input wire logic dual_addr_valid,
    input wire logic coef_valid,
    input wire logic [1:0] coef_type,
    input wire logic coef_data_valid,
    input wire logic coef_bit_valid,
    input wire logic coef_io_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ============================================================
    // Request qualifiers; a frozen clock enable takes nothing
    wire logic dreq = dual_valid && ce;
    wire logic creq = coef_valid && ce;
    // ============================================================
    // Dual operand path
    chk_dual_answer:
        assert property (dreq |=> dual_addr_valid) else $error("dual answer missing");
    chk_dual_cause:
        assert property (dual_addr_valid |-> $past(dreq)) else $error("dual answer uncaused");
    chk_instr_short:
        assert property (dreq && dual_instr |=> !x_long_out && !y_long_out)
        else $error("dual read not 16-bit");
    chk_pair_size:
        assert property (dreq && !dual_instr |=> x_long_out == $past(x_long)
            && y_long_out == $past(y_long)) else $error("pair size lost");
    chk_same_ptr:
        assert property (dreq && x_sel == y_sel && x_mode == 3'h0 && y_mode == 3'h0
            |=> x_addr == y_addr) else $error("same pointer differs");
    // Back-to-back use of one pointer shows the step with the page kept
    chk_inc_step:
        assert property ((dreq && x_mode == 3'h1 && !x_long && !psel)
            ##1 (dreq && x_sel == $past(x_sel) && x_mode == 3'h0 && !psel)
            |=> x_addr[15:0] == $past(x_addr[15:0]) + 16'h0001
            && x_addr[22:16] == $past(x_addr[22:16])) else $error("step wrong");
    // ============================================================
    // Coefficient path
    chk_coef_bit:
        assert property (creq && coef_type == 2'h1 |=> coef_bit_valid && !coef_data_valid
            && !coef_io_valid) else $error("bit access wrong");
    chk_coef_data:
        assert property (creq && coef_type == 2'h0 |=> coef_data_valid && !coef_bit_valid)
        else $error("data access wrong");
    cover property (dreq && dual_instr);
    cover property (dreq && x_sel == y_sel);
    cover property (creq && coef_type == 2'h2);
endmodule // dpa_top_chk

bind dpa_top dpa_top_chk i_dpa_top_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .dual_valid(dual_valid), .dual_instr(dual_instr), .x_sel(x_sel),
    .x_mode(x_mode), .x_long(x_long), .y_sel(y_sel), .y_mode(y_mode), .y_long(y_long),
    .x_addr(x_addr), .y_addr(y_addr), .x_long_out(x_long_out), .y_long_out(y_long_out),
    .dual_addr_valid(dual_addr_valid), .coef_valid(coef_valid), .coef_type(coef_type),
    .coef_data_valid(coef_data_valid), .coef_bit_valid(coef_bit_valid),
    .coef_io_valid(coef_io_valid));

/* tb/dpa_dmem.sv */
// Data-space read model answering both dual operand addresses
`timescale 1ns/1ps
module dpa_dmem #(
    parameter int LAT = 2
) (
    input wire logic pclk,
    input wire logic rd,
    input wire logic [22:0] xa,
    input wire logic [22:0] ya,
    output logic [15:0] xd,
    output logic [15:0] yd
);
    logic [7:0] cnt_q = 8'h00;
    initial begin
        xd = 16'h0000;
        yd = 16'h0000;
    end
    // Idle words invert each cycle so stale data is never mistaken for an answer
    always @(posedge pclk) begin
        if (rd) cnt_q <= 8'(LAT);
        else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
            xd <= xa[15:0] ^ 16'hA5A5;
            yd <= ya[15:0] ^ 16'hA5A5;
        end else begin
            xd <= ~xd;
            yd <= ~yd;
        end
    end
endmodule // dpa_dmem

/* tb/tb_top.sv */
// Self-checking bench for the dual pointer and coefficient address generator
`timescale 1ns/1ps
module tb_top;
    import dpa_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic dual_valid, dual_instr, x_long, y_long, coef_valid;
    logic x_long_out, y_long_out, dual_addr_valid, coef_data_valid, coef_bit_valid, coef_io_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] x_sel, x_mode, y_sel, y_mode;
    logic [22:0] x_addr, y_addr, coef_data_addr;
    logic [1:0] coef_type;
    logic [5:0] coef_bit_num;
    logic [15:0] coef_io_addr, xd, yd;
    int failures, samples_checked;
    dpa_top i_dpa_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .dual_valid(dual_valid),
        .dual_instr(dual_instr), .x_sel(x_sel), .x_mode(x_mode), .x_long(x_long),
        .y_sel(y_sel), .y_mode(y_mode), .y_long(y_long), .x_addr(x_addr), .y_addr(y_addr),
        .x_long_out(x_long_out), .y_long_out(y_long_out), .dual_addr_valid(dual_addr_valid),
        .coef_valid(coef_valid), .coef_type(coef_type), .coef_data_addr(coef_data_addr),
        .coef_bit_num(coef_bit_num), .coef_io_addr(coef_io_addr),
        .coef_data_valid(coef_data_valid), .coef_bit_valid(coef_bit_valid),
        .coef_io_valid(coef_io_valid));
    dpa_dmem i_dpa_dmem (.pclk(pclk), .rd(dual_addr_valid), .xa(x_addr), .ya(y_addr),
        .xd(xd), .yd(yd));
    // ============================================================
    // Clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ============================================================
    // Report and comparison tasks
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [22:0] got, input logic [22:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    // ============================================================
    // APB master; the wait for pready is bounded so a stuck slave ends the run
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1) begin
            failures++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pchk(input logic [7:0] idx, input logic [22:0] e);
        apb(1'b0, DPA_OFS_XPTR0 + (idx << 2), 32'h00000000);
        cmp_val(rd[22:0], e);
    endtask
    // Dual request is held for one edge; a second call back to back keeps it up
    task automatic drv(input logic [2:0] xs, xm, input logic xl, input logic [2:0] ys, ym,
        input logic yl, di);
        @(posedge pclk);
        dual_valid <= 1'b1;
        x_sel <= xs;
        x_mode <= xm;
        x_long <= xl;
        y_sel <= ys;
        y_mode <= ym;
        y_long <= yl;
        dual_instr <= di;
    endtask
    task automatic dchk(input logic [22:0] ex, ey);
        @(posedge pclk);
        dual_valid <= 1'b0;
        #1;
        cmp_bit(dual_addr_valid, 1'b1);
        cmp_val(x_addr, ex);
        cmp_val(y_addr, ey);
    endtask
    // ============================================================
    // Main sequence
    initial begin
        {psel, penable, pwrite, dual_valid, dual_instr, x_long, y_long, coef_valid} = 8'h00;
        {x_sel, x_mode, y_sel, y_mode, coef_type} = 14'h0000;
        {paddr, pwdata, pstrb} = 44'h00000000000;
        failures = 0;
        samples_checked = 0;
        ce = 1'b1;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h04, 32'h00051234);
        apb(1'b1, 8'h08, 32'h00020010);
        apb(1'b1, 8'h0C, 32'h00002000);
        apb(1'b1, 8'h00, 32'h00000008);
        apb(1'b1, DPA_OFS_TMP0, 32'h00000010);
        apb(1'b1, DPA_OFS_TMP1, 32'h00000003);
        drv(3'h1, DPA_MOD_INC, 1'b1, 3'h2, DPA_MOD_NONE, 1'b0, 1'b0);
        dchk(23'h051234, 23'h020010);
        pchk(8'h01, 23'h051236);
        drv(3'h1, DPA_MOD_DEC, 1'b1, 3'h2, DPA_MOD_INC, 1'b0, 1'b1);
        dchk(23'h051236, 23'h020010);
        pchk(8'h01, 23'h051235);
        pchk(8'h02, 23'h020011);
        drv(3'h2, DPA_MOD_ADD_IDX, 1'b0, 3'h1, DPA_MOD_BASE_IDX, 1'b0, 1'b0);
        dchk(23'h020011, 23'h051245);
        pchk(8'h02, 23'h020021);
        pchk(8'h01, 23'h051235);
        // Compat and aux-mode select both set: the same forms must still work
        apb(1'b1, DPA_OFS_CTRL, 32'h00000003);
        drv(3'h2, DPA_MOD_SUB_IDX, 1'b0, 3'h1, DPA_MOD_BASE_IDX, 1'b0, 1'b0);
        dchk(23'h020021, 23'h05123D);
        pchk(8'h02, 23'h020019);
        drv(3'h2, DPA_MOD_ADD_T1, 1'b0, 3'h3, DPA_MOD_SUB_T1, 1'b0, 1'b0);
        dchk(23'h020019, 23'h002000);
        pchk(8'h02, 23'h02001C);
        pchk(8'h03, 23'h001FFD);
        // Pointer 3 circular, pointer 2 of the same pair stays linear
        apb(1'b1, DPA_OFS_ST2, 32'h00000008);
        apb(1'b1, DPA_OFS_BUFFER_START_PAIR01 + 8'h04, 32'h00000100);
        drv(3'h3, DPA_MOD_NONE, 1'b0, 3'h2, DPA_MOD_NONE, 1'b0, 1'b0);
        dchk(23'h0020FD, 23'h02001C);
        drv(3'h5, DPA_MOD_INC, 1'b0, 3'h5, DPA_MOD_NONE, 1'b0, 1'b0);
        drv(3'h5, DPA_MOD_NONE, 1'b0, 3'h5, DPA_MOD_NONE, 1'b0, 1'b0);
        dchk(23'h000001, 23'h000001);
        apb(1'b0, DPA_OFS_LASTX, 32'h00000000);
        cmp_val(rd[22:0], 23'h000001);
        apb(1'b0, DPA_OFS_LASTY, 32'h00000000);
        cmp_val(rd[22:0], 23'h000001);
        apb(1'b1, DPA_OFS_XCOEF, 32'h007F1234);
        for (int t = 0; t < 4; t++) begin
            @(posedge pclk);
            coef_valid <= 1'b1;
            coef_type <= 2'(t);
            @(posedge pclk);
            coef_valid <= 1'b0;
            #1;
            cmp_bit(coef_data_valid, t == 0);
            cmp_bit(coef_bit_valid, t == 1);
            cmp_bit(coef_io_valid, t == 2);
            if (t == 0) cmp_val(coef_data_addr, 23'h7F1234);
            if (t == 1) cmp_val(23'(coef_bit_num), 23'h000034);
            if (t == 2) cmp_val(23'(coef_io_addr), 23'h001234);
        end
        apb(1'b0, 8'h50, 32'h00000000);
        cmp_bit(err, 1'b1);
        cmp_val(rd[22:0], 23'h000000);
        summarize();
    end
endmodule // tb_top
